// *** inc/rpm_pkg.sv ***
/*
 * Shared constants, types and helpers for the receive pattern match block.
 * Assumes a 16-bit register port with word addresses and a byte-wide
 * receive stream that flags the first byte after the frame delimiter.
 */
`default_nettype none
package rpm_pkg;

	// ==========================================================
	// Register offsets (word addresses on the register port)
	localparam logic [15:0] OFF_PAT_BASE = 16'h04A8; // Bytes 0 and 1
	localparam logic [15:0] OFF_PAT_W30  = 16'h04C5; // Bytes 58 and 59
	localparam logic [15:0] OFF_PAT_W31  = 16'h04C6; // Bytes 60 and 61
	localparam logic [15:0] OFF_PAT_W32  = 16'h04C7; // Bytes 62 and 63
	localparam logic [15:0] OFF_MASK_W1  = 16'h04C8;
	localparam logic [15:0] OFF_MASK_W2  = 16'h04C9;
	localparam logic [15:0] OFF_MASK_W3  = 16'h04CA;
	localparam logic [15:0] OFF_MASK_W4  = 16'h04CB;
	localparam logic [15:0] OFF_CTRL     = 16'h04CC;
	localparam logic [15:0] OFF_STAT     = 16'h04CD;

	// ==========================================================
	// Field layout and reset values
	localparam int          PAT_WORDS  = 32;
	localparam int          PAT_BYTES  = 64;
	localparam int          MASK_WORDS = 4;
	localparam int          START_W    = 6;
	localparam logic [15:0] PAT_RST    = 16'h0000;
	localparam logic [15:0] MASK_RST   = 16'h0000;
	localparam logic [5:0]  START_RST  = 6'h00;
	localparam int          STAT_MATCH = 0;
	localparam int          STAT_BUSY  = 1;
	localparam logic [5:0]  POS_LAST   = 6'h3F;
	localparam logic [6:0]  IDX_MAX    = 7'h7F;

	// ==========================================================
	// Types
	typedef logic [PAT_BYTES-1:0][7:0] rpm_pat_t;

	typedef enum logic [1:0] {
		CMP_IDLE = 2'h0,
		CMP_RUN  = 2'h1,
		CMP_DONE = 2'h3
	} rpm_cmp_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} rpm_bus_s;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic [7:0] data;
	} rpm_rx_s;

	// ==========================================================
	// A masked byte never misses; an unmasked one must match
	function automatic logic rpm_miss(input logic [7:0] pat,
		input logic msk, input logic [7:0] dat);
		rpm_miss = !msk && (pat != dat);
	endfunction : rpm_miss

endpackage : rpm_pkg
`default_nettype wire

// *** rtl/rpm_cmp.sv ***
/*
 * Byte comparator: walks a received frame and compares 64 bytes from the
 * configured start point against the pattern, honouring the byte mask.
 * Assumes pattern, mask and start are stable while a frame is received.
 */
`timescale 1ns/100ps
`default_nettype none
module rpm_cmp (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	input  wire rpm_pkg::rpm_rx_s rx_in,
	input  wire rpm_pkg::rpm_pat_t pat_in,
	input  wire logic [63:0]      mask_in,
	input  wire logic [5:0]       start_in,
	output logic                  act_out,
	output logic [5:0]            pos_out,
	output logic                  match_out,
	output logic                  busy_out
);
	import rpm_pkg::*;

	rpm_cmp_e   state_r;
	logic [6:0] cnt_r;
	logic       fail_r;
	logic [6:0] idx;
	logic [6:0] off;
	logic       in_win;
	logic       miss;
	logic       fail_eff;
	logic       last;

	// ==========================================================
	// Position of the current byte relative to the start point
	always_comb
	begin
		idx      = rx_in.sof ? 7'h00 : cnt_r;
		off      = idx - {1'b0, start_in};
		in_win   = (idx >= {1'b0, start_in}) && !off[6];
		act_out  = rx_in.valid && (rx_in.sof || state_r == CMP_RUN) && in_win;
		pos_out  = off[5:0];
		miss     = rpm_miss(pat_in[pos_out], mask_in[pos_out], rx_in.data);
		fail_eff = rx_in.sof ? 1'b0 : fail_r;
		last     = act_out && (pos_out == POS_LAST);
	end

	assign busy_out = (state_r == CMP_RUN);

	// Byte counter saturates so very long frames never wrap into the window
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cnt_r <= 7'h00;
		else if (rx_in.valid)
			cnt_r <= (idx == IDX_MAX) ? IDX_MAX : idx + 7'h01;
	end

	// Any unmasked mismatch spoils the rest of the frame
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			fail_r <= 1'b0;
		else if (rx_in.valid && rx_in.sof)
			fail_r <= act_out && miss;
		else if (act_out)
			fail_r <= fail_r || miss;
	end

	// Frame walk; a new delimiter always restarts the comparison
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state_r <= CMP_IDLE;
		else if (rx_in.valid && (rx_in.sof || state_r == CMP_RUN))
		begin
			if (last || rx_in.eof)
				state_r <= last ? CMP_DONE : CMP_IDLE;
			else
				state_r <= CMP_RUN;
		end
		else if (rx_in.valid && rx_in.eof)
			state_r <= CMP_IDLE;
	end

	// Match pulse once the last pattern byte passes without a miss
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			match_out <= 1'b0;
		else
			match_out <= last && !fail_eff && !miss;
	end

endmodule : rpm_cmp
`default_nettype wire

// *** rtl/rpm_top.sv ***
/*
 * Receive pattern match: pattern, byte mask and start point registers on a
 * 16-bit register port, plus the comparator that walks received frames.
 * Assumes a one-clock register port with read data one cycle after the
 * read strobe, and a receive stream synchronous to sys_clk_in.
 */

// Function
// - Word at 0x04C6 holds pattern byte 61 high, byte 60 low, reset zero.
// - Word at 0x04C7 holds pattern byte 63 high, byte 62 low, reset zero.
// - Mask bit one excludes its pattern byte from comparison; zero includes it.
// - First mask word covers pattern bytes 0 through 15.
// - Second mask word covers pattern bytes 16 through 31.
// - Third mask word covers bytes 32-47, fourth bytes 48-63, all read-write.
// - Six-bit start point sets bytes skipped after the delimiter before comparing.
// - Start value zero compares first byte after delimiter; each step one later.
// - Start point resets to zero; software sets twelve to skip both addresses.
// - Upper ten bits of the control word are read-only zero.
// - Lower pattern bytes fill preceding words, two each, odd byte high.
`timescale 1ns/100ps
`default_nettype none
module rpm_top (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	input  wire rpm_pkg::rpm_bus_s bus_in,
	output logic [15:0]            rdata_out,
	input  wire rpm_pkg::rpm_rx_s  rx_in,
	output logic                   match_out,
	output logic                   busy_out
);
	import rpm_pkg::*;

	// ==========================================================
	// Configuration storage
	logic [15:0]     pat_mem_r [PAT_WORDS];
	logic [15:0]     mask_r    [MASK_WORDS];
	logic [5:0]      start_r;
	logic            matched_r;
	logic [15:0]     rdata_nxt;
	rpm_pat_t        pat_vec;
	logic [63:0]     mask_vec;
	logic [15:0]     pat_idx;
	logic [15:0]     mask_idx;
	logic            pat_hit;
	logic            mask_hit;
	logic            cmp_act;
	logic [5:0]      cmp_pos;

	// ==========================================================
	// Address decode shared by reads and writes
	always_comb
	begin
		pat_idx  = bus_in.addr - OFF_PAT_BASE;
		mask_idx = bus_in.addr - OFF_MASK_W1;
		pat_hit  = (bus_in.addr >= OFF_PAT_BASE) && (bus_in.addr <= OFF_PAT_W32);
		mask_hit = (bus_in.addr >= OFF_MASK_W1) && (bus_in.addr <= OFF_MASK_W4);
	end

	// Pattern words: even byte low, odd byte high, 0x04A8 up to 0x04C7
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < PAT_WORDS; i++)
				pat_mem_r[i] <= PAT_RST;
		end
		else if (bus_in.wr && pat_hit)
			pat_mem_r[pat_idx[4:0]] <= bus_in.wdata;
	end

	// Mask words, one bit per pattern byte
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < MASK_WORDS; i++)
				mask_r[i] <= MASK_RST;
		end
		else if (bus_in.wr && mask_hit)
			mask_r[mask_idx[1:0]] <= bus_in.wdata;
	end

	// Start point resets to zero; software must set twelve to skip addresses
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			start_r <= START_RST;
		else if (bus_in.wr && bus_in.addr == OFF_CTRL)
			start_r <= bus_in.wdata[START_W-1:0];
	end

	// Match flag: new frame clears it, a match in the same cycle wins
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			matched_r <= 1'b0;
		else if (match_out)
			matched_r <= 1'b1;
		else if (rx_in.valid && rx_in.sof)
			matched_r <= 1'b0;
	end

	// ==========================================================
	// Read path; unmapped addresses read zero
	always_comb
	begin
		rdata_nxt = 16'h0000;
		if (pat_hit)
			rdata_nxt = pat_mem_r[pat_idx[4:0]];
		else if (mask_hit)
			rdata_nxt = mask_r[mask_idx[1:0]];
		else if (bus_in.addr == OFF_CTRL)
			rdata_nxt = {10'h000, start_r};
		else if (bus_in.addr == OFF_STAT)
		begin
			rdata_nxt[STAT_MATCH] = matched_r;
			rdata_nxt[STAT_BUSY]  = busy_out;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_out <= 16'h0000;
		else
			rdata_out <= bus_in.rd ? rdata_nxt : 16'h0000;
	end

	// ==========================================================
	// Flatten storage for the comparator
	always_comb
	begin
		for (int i = 0; i < PAT_WORDS; i++)
		begin
			pat_vec[2*i]   = pat_mem_r[i][7:0];
			pat_vec[2*i+1] = pat_mem_r[i][15:8];
		end
		mask_vec = {mask_r[3], mask_r[2], mask_r[1], mask_r[0]};
	end

	rpm_cmp u_cmp (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.rx_in      (rx_in),
		.pat_in     (pat_vec),
		.mask_in    (mask_vec),
		.start_in   (start_r),
		.act_out    (cmp_act),
		.pos_out    (cmp_pos),
		.match_out  (match_out),
		.busy_out   (busy_out)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_pat31;
		bus_in.wr && bus_in.addr == OFF_PAT_W31 |=>
			pat_vec[61] == $past(bus_in.wdata[15:8]) &&
			pat_vec[60] == $past(bus_in.wdata[7:0]);
	endproperty
	a_pat31: assert property (p_pat31) else $error("byte 60/61 not stored");

	property p_pat32;
		bus_in.wr && bus_in.addr == OFF_PAT_W32 ##1 bus_in.rd && bus_in.addr == OFF_PAT_W32
			|=> rdata_out == {pat_vec[63], pat_vec[62]};
	endproperty
	a_pat32: assert property (p_pat32) else $error("byte 62/63 readback wrong");

	property p_pat30;
		bus_in.wr && bus_in.addr == OFF_PAT_W30 |=>
			{pat_vec[59], pat_vec[58]} == $past(bus_in.wdata);
	endproperty
	a_pat30: assert property (p_pat30) else $error("byte 58/59 misplaced");

	property p_mask1;
		bus_in.wr && bus_in.addr == OFF_MASK_W1 |=> mask_vec[15:0] == $past(bus_in.wdata);
	endproperty
	a_mask1: assert property (p_mask1) else $error("mask bytes 0-15 wrong");

	property p_mask2;
		bus_in.wr && bus_in.addr == OFF_MASK_W2 |=> mask_vec[31:16] == $past(bus_in.wdata);
	endproperty
	a_mask2: assert property (p_mask2) else $error("mask bytes 16-31 wrong");

	property p_mask34;
		bus_in.wr && bus_in.addr == OFF_MASK_W4 |=>
			mask_vec[63:48] == $past(bus_in.wdata) && $stable(mask_vec[47:32]);
	endproperty
	a_mask34: assert property (p_mask34) else $error("mask bytes 48-63 wrong");

	property p_start;
		bus_in.wr && bus_in.addr == OFF_CTRL |=> start_r == $past(bus_in.wdata[5:0]);
	endproperty
	a_start: assert property (p_start) else $error("start point not stored");

	property p_first;
		rx_in.valid && rx_in.sof && start_r == 6'h00 |-> cmp_act && cmp_pos == 6'h00;
	endproperty
	a_first: assert property (p_first) else $error("start zero skips first byte");

	property p_rst_start;
		@(posedge sys_clk_in) $rose(rst_n_in) |-> start_r == START_RST;
	endproperty
	a_rst_start: assert property (p_rst_start) else $error("start reset wrong");

	property p_ctrl_rsvd;
		bus_in.rd && bus_in.addr == OFF_CTRL |=> rdata_out[15:6] == 10'h000;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits nonzero");

	property p_miss;
		cmp_act && !mask_vec[cmp_pos] && rx_in.data != pat_vec[cmp_pos]
			&& cmp_pos != POS_LAST |=> !match_out;
	endproperty
	a_miss: assert property (p_miss) else $error("unmasked miss ignored");

	property p_match;
		match_out |-> $past(cmp_act) && $past(cmp_pos) == POS_LAST;
	endproperty
	a_match: assert property (p_match) else $error("match without last byte");

	property p_mask3;
		bus_in.wr && bus_in.addr == OFF_MASK_W3 |=>
			mask_vec[47:32] == $past(bus_in.wdata) && $stable(mask_vec[15:0]);
	endproperty
	a_mask3: assert property (p_mask3) else $error("mask bytes 32-47 wrong");

	// ==========================================================
	// Readback, reset, hold, start skip, busy and match flag checks
	// Read data mirror the stored word of the strobe cycle
	property p_mask_rd;
		bus_in.rd && bus_in.addr == OFF_MASK_W1 |=>
			rdata_out == $past(mask_vec[15:0]);
	endproperty
	a_mask_rd: assert property (p_mask_rd) else $error("mask word 1 readback wrong");

	property p_pat_rd;
		bus_in.rd && bus_in.addr == OFF_PAT_W31 |=>
			rdata_out == {$past(pat_vec[61]), $past(pat_vec[60])};
	endproperty
	a_pat_rd: assert property (p_pat_rd) else $error("byte 60/61 readback wrong");

	property p_ctrl_rd;
		bus_in.rd && bus_in.addr == OFF_CTRL |=>
			rdata_out[5:0] == $past(start_r);
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("start readback wrong");

	// Pattern bytes 60 to 63 and the mask come out of reset cleared
	property p_rst_cfg;
		@(posedge sys_clk_in) $rose(rst_n_in) |->
			pat_vec[63:60] == 32'h00000000 && mask_vec == 64'h0000000000000000;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("config reset wrong");

	// Storage changes only on a write to its own register group
	property p_mask_hold;
		!(bus_in.wr && mask_hit) |=> $stable(mask_vec);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask drifted");

	property p_pat_hold;
		!(bus_in.wr && pat_hit) |=> $stable(pat_vec);
	endproperty
	a_pat_hold: assert property (p_pat_hold) else $error("pattern drifted");

	property p_start_hold;
		!(bus_in.wr && bus_in.addr == OFF_CTRL) |=> $stable(start_r);
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start drifted");

	// A nonzero start point leaves the first byte after the delimiter out of the compare
	property p_skip;
		rx_in.valid && rx_in.sof && start_r != 6'h00 |-> !cmp_act;
	endproperty
	a_skip: assert property (p_skip) else $error("byte before start compared");

	property p_busy;
		rx_in.valid && rx_in.sof && !rx_in.eof && !(cmp_act && cmp_pos == POS_LAST)
			|=> busy_out;
	endproperty
	a_busy: assert property (p_busy) else $error("no compare after delimiter");

	property p_flag;
		match_out |=> matched_r;
	endproperty
	a_flag: assert property (p_flag) else $error("match flag not set");

	// Scenarios the bench is meant to reach
	c_match: cover property (match_out);
	c_b2b:   cover property (bus_in.wr ##1 bus_in.rd);
	c_late:  cover property (rx_in.valid && rx_in.sof && start_r == 6'h0C ##[1:80] match_out);
	c_abort: cover property (busy_out ##1 rx_in.valid && rx_in.eof && !cmp_act);
	c_read:  cover property (bus_in.rd && bus_in.addr == OFF_STAT ##1 rdata_out[STAT_MATCH]);

endmodule : rpm_top
`default_nettype wire

// *** verification/rpm_rx_src.sv ***
/*
 * Line-side frame source: plays one received frame, byte per clock.
 * Assumes the bench loads frame_in and len_in before pulsing go_in.
 */
`timescale 1ns/100ps
`default_nettype none
module rpm_rx_src (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              go_in,
	input  wire logic [7:0]        len_in,
	input  wire logic [127:0][7:0] frame_in,
	output var rpm_pkg::rpm_rx_s   rx_out,
	output var logic               done_out
);
	import rpm_pkg::*;

	logic       run_r;
	logic [7:0] idx_r;

	// ==========================================================
	// Frame player; idle data toggles so stale bytes never look valid
	always @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			run_r    <= 1'b0;
			idx_r    <= 8'h00;
			done_out <= 1'b0;
			rx_out   <= '0;
		end
		else
		begin
			done_out <= 1'b0;
			if (go_in)
			begin
				run_r <= 1'b1;
				idx_r <= 8'h00;
			end
			if (run_r)
			begin
				rx_out.valid <= 1'b1;
				rx_out.sof   <= (idx_r == 8'h00); // First byte after delimiter
				rx_out.eof   <= (idx_r == len_in - 8'h01);
				rx_out.data  <= frame_in[idx_r[6:0]];
				idx_r        <= idx_r + 8'h01;
				if (idx_r == len_in - 8'h01)
				begin
					run_r    <= 1'b0;
					done_out <= 1'b1;
				end
			end
			else
			begin
				rx_out.valid <= 1'b0;
				rx_out.sof   <= 1'b0;
				rx_out.eof   <= 1'b0;
				rx_out.data  <= ~rx_out.data;
			end
		end
	end
endmodule : rpm_rx_src
`default_nettype wire

// *** verification/rpm_top_tb_top.sv ***
/*
 * Self-checking bench for the receive pattern match block.
 * Assumes rpm_pkg, rpm_top and the frame source model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module rpm_top_tb_top;
	import rpm_pkg::*;

	logic              sys_clk = 1'b0;
	logic              rst_n   = 1'b0;
	rpm_bus_s          bus     = '0;
	rpm_rx_s           rx;
	logic [15:0]       rdata;
	logic              match;
	logic              busy;
	logic              go      = 1'b0;
	logic              done;
	logic [127:0][7:0] frame   = '0;
	logic [7:0]        flen    = 8'h00;
	int                bad_count = 0;
	int                samples_checked = 0;
	int                hits = 0;

	rpm_top dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .bus_in(bus), .rdata_out(rdata),
		.rx_in(rx), .match_out(match), .busy_out(busy));
	rpm_rx_src src_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .go_in(go), .len_in(flen),
		.frame_in(frame), .rx_out(rx), .done_out(done));

	// ==========================================================
	// Clock, and a match counter kept apart so no pulse is missed
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (match === 1'b1)
			hits <= hits + 1;

	// ==========================================================
	// Shared tasks
	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus <= '0;
	endtask : wr

	// Read data is only valid in the cycle after the strobe
	task automatic rd_chk(input string n, input logic [15:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		chk(n, e, rdata);
	endtask : rd_chk

	// Write, then read the same word in the very next cycle
	task automatic wr_rd_chk(input string n, input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		chk(n, d, rdata);
	endtask : wr_rd_chk

	// Pattern byte p, distinct for every position
	function automatic logic [7:0] pb(input int p);
		return 8'(p * 37 + 11);
	endfunction : pb

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		int i;
		for (i = 0; i < 7; i++)
			rd_chk("reset value", OFF_PAT_W31 + 16'(i), 16'h0000);
		wr(OFF_PAT_W31, 16'hBBAA);
		wr(OFF_PAT_W32, 16'hDDCC);
		for (i = 0; i < 4; i++)
			wr(OFF_MASK_W1 + 16'(i), 16'hA5F0 ^ 16'(i));
		wr(OFF_CTRL, 16'hFFFF);
		wr(16'h04CE, 16'h1234);
		wr(OFF_STAT, 16'hFFFF);
		rd_chk("pattern word 31", OFF_PAT_W31, 16'hBBAA);
		rd_chk("pattern word 32", OFF_PAT_W32, 16'hDDCC);
		for (i = 0; i < 4; i++)
			rd_chk("mask word", OFF_MASK_W1 + 16'(i), 16'hA5F0 ^ 16'(i));
		rd_chk("control word", OFF_CTRL, 16'h003F);
		rd_chk("unmapped word", 16'h04CE, 16'h0000);
		rd_chk("status word", OFF_STAT, 16'h0000);
		wr_rd_chk("pattern word 32 back to back", OFF_PAT_W32, 16'h7E81);
		for (i = 0; i < 32; i++)
			wr(OFF_PAT_BASE + 16'(i), {pb(2 * i + 1), pb(2 * i)});
	endtask : t_regs

	// Frame with lead filler bytes, one corrupted byte and one mask bit
	task automatic t_frame(input logic [5:0] st, input int lead, input int bad,
		input int mw, input int mb, input int exp);
		int i;
		int h0;
		wr(OFF_CTRL, {10'h000, st});
		for (i = 0; i < 4; i++)
			wr(OFF_MASK_W1 + 16'(i), (i == mw) ? 16'(16'h0001 << mb) : 16'h0000);
		for (i = 0; i < 128; i++)
			frame[i] = (i < lead) ? 8'hEE : pb(i - lead) ^ ((i - lead == bad) ? 8'hFF : 8'h00);
		flen <= 8'(lead + 66);
		h0 = hits;
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		i = 0;
		while (i < 300 && done !== 1'b1)
		begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		repeat (3) @(posedge sys_clk);
		#1;
		chk("match count", 16'(exp), 16'(hits - h0));
		chk("busy after frame", 16'h0000, {15'h0000, busy});
		rd_chk("status word", OFF_STAT, 16'(exp));
	endtask : t_frame

	// ==========================================================
	// Main sequence
	initial
	begin
		int i;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_frame(6'h00, 0, 64, 4, 0, 1);
		t_frame(6'h01, 1, 64, 4, 0, 1);
		t_frame(6'h01, 0, 64, 4, 0, 0);
		t_frame(6'h0C, 12, 64, 4, 0, 1);
		for (i = 0; i < 4; i++)
		begin
			t_frame(6'h0C, 12, 16 * i + 5, 4, 0, 0);
			t_frame(6'h0C, 12, 16 * i + 5, i, 5, 1);
			t_frame(6'h0C, 12, 16 * i + 5, i, 6, 0);
		end
		wrap_up();
	end

	// Watchdog, well beyond the fewer than two thousand cycles the run needs
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		wrap_up();
	end
endmodule : rpm_top_tb_top
`default_nettype wire
